// File: rtl/fem_flag8.sv
// one live status byte with its latched companion
// assumes cond_i is synchronous to clk_i; clr_i is a one-cycle pulse
`timescale 1ns/1ns
module fem_flag8
    import fem_pkg::*;
#(
    parameter fem_byte_t LIVE_BITS  = 8'hFF,
    parameter fem_byte_t LATCH_BITS = 8'hFF
) (
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      arst_n_i,
    // condition in and read-clear strobe
    input  wire fem_byte_t cond_i,
    input  wire logic      clr_i,
    // status out
    output fem_byte_t      live_o,
    output fem_byte_t      latch_o
);

    fem_byte_t live;
    fem_byte_t latch;
    fem_byte_t next_live;
    fem_byte_t next_latch;

    // live follows the condition; latch holds until read, set beats clear
    always_comb begin
        next_live  = cond_i & LIVE_BITS;
        next_latch = clr_i ? 8'h00 : latch;
        next_latch = next_latch | (cond_i & LATCH_BITS);
    end

    // reset leaves every bit clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            live  <= 8'h00;
            latch <= 8'h00;
        end else begin
            live  <= next_live;
            latch <= next_latch;
        end
    end

    assign live_o  = live;
    assign latch_o = latch;

endmodule

// File: rtl/fem_map.svh
// register offsets, reset values and bit layouts of the fault event block
// assumes offsets are register indices; the bus byte address is index * 4
`ifndef FEM_MAP_SVH
`define FEM_MAP_SVH

// register indices
`define FEM_OFS_MASK_LIM   8'h3B
`define FEM_OFS_MASK_GAIN  8'h3C
`define FEM_OFS_MASK_CB    8'h3D
`define FEM_OFS_MASK_TS    8'h40
`define FEM_OFS_MASK_PL    8'h41
`define FEM_OFS_LIVE_LF    8'h42
`define FEM_OFS_LIVE_CG    8'h43
`define FEM_OFS_LIVE_CB    8'h44
`define FEM_OFS_LIVE_TS    8'h47
`define FEM_OFS_LIVE_PL    8'h48
`define FEM_OFS_LTCH_LF    8'h49
`define FEM_OFS_LTCH_CG    8'h4A
`define FEM_OFS_LTCH_CB    8'h4B
`define FEM_OFS_LTCH_TS    8'h4F
`define FEM_OFS_LTCH_PL    8'h50
`define FEM_OFS_LTCH_TYPE  8'h51

// reset values of the mask registers
`define FEM_RST_MASK_CB    8'hDF
`define FEM_RST_MASK_TS    8'hF6
`define FEM_RST_MASK_PL    8'h00

// implemented bits of each live and latched register
`define FEM_BITS_FULL      8'hFF
`define FEM_BITS_LIVE_CG   8'h45
`define FEM_BITS_LTCH_CG   8'h41
`define FEM_BITS_CB        8'hA0

// bits that imply shutdown in each live register
`define FEM_SHDN_LF        8'h07
`define FEM_SHDN_CG        8'h40
`define FEM_SHDN_CB        8'hA0
`define FEM_SHDN_TS        8'h0F
`define FEM_SHDN_PL        8'h80

// field positions used outside the byte-wide paths
`define FEM_BIT_AUDIO_CLK  2
`define FEM_BIT_CRC        6
`define FEM_BIT_GAIN_LIM   0
`define FEM_TYPE_W         3

`endif

// File: rtl/fem_pkg.sv
// types shared by the fault event block
// assumes fem_map.svh carries all numeric constants
package fem_pkg;

    typedef logic [7:0] fem_byte_t;

    // one group of live fault and event conditions, implemented bits only, grouped by register
    typedef struct packed {
        // limiter and fault group
        logic brownout_mute_live;
        logic brownout_hold_live;
        logic limiter_max_atten_live;
        logic below_inflection_live;
        logic limiter_active_live;
        logic audio_clock_error_live;
        logic overcurrent_live;
        logic overtemperature_live;
        // crc and gate group
        logic fuse_memory_crc_live;
        logic noise_gate_active_live;
        logic gain_limiter_live;
        // clock and battery group
        logic derived_clock_error_live;
        logic battery_undervoltage_live;
        // thermal and supply group
        logic [3:0] temp_over_live;   // 105,115,125,135 from msb
        logic regulator_undervoltage_live;
        logic regulator_overvoltage_live;
        logic regulator_overload_live;
        logic power_stage_undervoltage_live;
        // protection level group
        logic thermal_threshold_two_live;
        logic thermal_threshold_one_live;
        logic supply_difference_live;
        logic brownout_active_live;
        logic [3:0] brownout_level_live; // level 3 at msb
    } fem_cond_s;

    // register indices as seen by the bus decoder
    typedef logic [7:0] fem_index_t;

endpackage

// File: rtl/fem_top.sv
// fault event masks, live status and latched status behind Avalon-MM
// assumes ADDRESS_I is a word index; conditions are synchronous levels
`timescale 1ns/1ns
`include "fem_map.svh"
module fem_top
    import fem_pkg::*;
(
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        ARST_N_I,
    // avalon-mm slave
    input  wire logic [7:0]  ADDRESS_I,
    input  wire logic        READ_I,
    input  wire logic        WRITE_I,
    input  wire logic [31:0] WRITEDATA_I,
    input  wire logic [3:0]  BYTEENABLE_I,
    output logic [31:0]      READDATA_O,
    output logic             WAITREQUEST_O,
    // fault and event conditions
    input  wire fem_cond_s   COND_I,
    input  wire logic [2:0]  CLK_ERR_TYPE_I,
    // masks held by the lower mask registers elsewhere
    input  wire logic [7:0]  MASK_LIM_I,
    input  wire logic [7:0]  MASK_GAIN_I,
    // results
    output logic             IRQ_O,
    output logic             SHUTDOWN_O
);

    ////////////////////////////////////////////////////////////////////////
    // condition bytes in register bit order

    fem_byte_t cond_lf;
    fem_byte_t cond_cg;
    fem_byte_t cond_cb;
    fem_byte_t cond_ts;
    fem_byte_t cond_pl;

    // pack each group the way software sees it
    always_comb begin
        cond_lf = {COND_I.brownout_mute_live,
                   COND_I.brownout_hold_live,
                   COND_I.limiter_max_atten_live,
                   COND_I.below_inflection_live,
                   COND_I.limiter_active_live,
                   COND_I.audio_clock_error_live,
                   COND_I.overcurrent_live,
                   COND_I.overtemperature_live};
        cond_cg = {1'b0, COND_I.fuse_memory_crc_live,
                   3'h0, COND_I.noise_gate_active_live,
                   1'b0, COND_I.gain_limiter_live};
        cond_cb = {COND_I.derived_clock_error_live, 1'b0,
                   COND_I.battery_undervoltage_live, 5'h00};
        cond_ts = {COND_I.temp_over_live,
                   COND_I.regulator_undervoltage_live,
                   COND_I.regulator_overvoltage_live,
                   COND_I.regulator_overload_live,
                   COND_I.power_stage_undervoltage_live};
        cond_pl = {COND_I.thermal_threshold_two_live,
                   COND_I.thermal_threshold_one_live,
                   COND_I.supply_difference_live,
                   COND_I.brownout_active_live,
                   COND_I.brownout_level_live};
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: every access takes exactly two cycles

    logic      ack;
    logic      next_ack;
    logic      req;
    logic      wr_take;
    logic      rd_take;
    fem_index_t idx;

    assign req     = READ_I | WRITE_I;
    assign idx     = ADDRESS_I;
    assign wr_take = WRITE_I & ack & BYTEENABLE_I[0];
    // latched bytes clear on the edge that captures the read data, so an
    // event arriving while the read waits is kept for the next read
    assign rd_take = READ_I & ~ack;

    // one wait cycle gives the read mux a flop stage to settle into
    always_comb begin
        next_ack = req & ~ack;
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ack <= 1'b0;
        end else begin
            ack <= next_ack;
        end
    end

    assign WAITREQUEST_O = req & ~ack;

    ////////////////////////////////////////////////////////////////////////
    // mask registers

    fem_byte_t mask_cb;
    fem_byte_t mask_ts;
    fem_byte_t mask_pl;
    fem_byte_t next_mask_cb;
    fem_byte_t next_mask_ts;
    fem_byte_t next_mask_pl;

    // writes land on the edge where waitrequest is low; lane 0 only
    always_comb begin
        next_mask_cb = mask_cb;
        next_mask_ts = mask_ts;
        next_mask_pl = mask_pl;
        if (wr_take) begin
            case (idx)
                `FEM_OFS_MASK_CB: next_mask_cb = WRITEDATA_I[7:0];
                `FEM_OFS_MASK_TS: next_mask_ts = WRITEDATA_I[7:0];
                `FEM_OFS_MASK_PL: next_mask_pl = WRITEDATA_I[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mask_cb <= `FEM_RST_MASK_CB;
            mask_ts <= `FEM_RST_MASK_TS;
            mask_pl <= `FEM_RST_MASK_PL;
        end else begin
            mask_cb <= next_mask_cb;
            mask_ts <= next_mask_ts;
            mask_pl <= next_mask_pl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live and latched status, one instance per register pair

    fem_byte_t live_lf;
    fem_byte_t live_cg;
    fem_byte_t live_cb;
    fem_byte_t live_ts;
    fem_byte_t live_pl;
    fem_byte_t ltch_lf;
    fem_byte_t ltch_cg;
    fem_byte_t ltch_cb;
    fem_byte_t ltch_ts;
    fem_byte_t ltch_pl;

    fem_flag8 #(
        .LIVE_BITS  (`FEM_BITS_FULL),
        .LATCH_BITS (`FEM_BITS_FULL)
    ) u_lf (
        .clk_i    (CLOCK_I),
        .arst_n_i (ARST_N_I),
        .cond_i   (cond_lf),
        .clr_i    (rd_take && idx == `FEM_OFS_LTCH_LF),
        .live_o   (live_lf),
        .latch_o  (ltch_lf)
    );

    fem_flag8 #(
        .LIVE_BITS  (`FEM_BITS_LIVE_CG),
        .LATCH_BITS (`FEM_BITS_LTCH_CG)
    ) u_cg (
        .clk_i    (CLOCK_I),
        .arst_n_i (ARST_N_I),
        .cond_i   (cond_cg),
        .clr_i    (rd_take && idx == `FEM_OFS_LTCH_CG),
        .live_o   (live_cg),
        .latch_o  (ltch_cg)
    );

    fem_flag8 #(
        .LIVE_BITS  (`FEM_BITS_CB),
        .LATCH_BITS (`FEM_BITS_CB)
    ) u_cb (
        .clk_i    (CLOCK_I),
        .arst_n_i (ARST_N_I),
        .cond_i   (cond_cb),
        .clr_i    (rd_take && idx == `FEM_OFS_LTCH_CB),
        .live_o   (live_cb),
        .latch_o  (ltch_cb)
    );

    fem_flag8 #(
        .LIVE_BITS  (`FEM_BITS_FULL),
        .LATCH_BITS (`FEM_BITS_FULL)
    ) u_ts (
        .clk_i    (CLOCK_I),
        .arst_n_i (ARST_N_I),
        .cond_i   (cond_ts),
        .clr_i    (rd_take && idx == `FEM_OFS_LTCH_TS),
        .live_o   (live_ts),
        .latch_o  (ltch_ts)
    );

    fem_flag8 #(
        .LIVE_BITS  (`FEM_BITS_FULL),
        .LATCH_BITS (`FEM_BITS_FULL)
    ) u_pl (
        .clk_i    (CLOCK_I),
        .arst_n_i (ARST_N_I),
        .cond_i   (cond_pl),
        .clr_i    (rd_take && idx == `FEM_OFS_LTCH_PL),
        .live_o   (live_pl),
        .latch_o  (ltch_pl)
    );

    ////////////////////////////////////////////////////////////////////////
    // audio clock error type, caught while the error is present

    logic [`FEM_TYPE_W-1:0] clk_type;
    logic [`FEM_TYPE_W-1:0] next_clk_type;

    // a read clears it, but a type seen in the same cycle survives
    always_comb begin
        next_clk_type = clk_type;
        if (rd_take && idx == `FEM_OFS_LTCH_TYPE) begin
            next_clk_type = '0;
        end
        if (cond_lf[`FEM_BIT_AUDIO_CLK]) begin
            next_clk_type = next_clk_type | CLK_ERR_TYPE_I;
        end
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            clk_type <= '0;
        end else begin
            clk_type <= next_clk_type;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt and shutdown summaries

    fem_byte_t mask_cg;
    logic      next_irq;
    logic      irq;
    logic      next_shdn;
    logic      shdn;

    // crc error has no mask bit, so it always reaches the interrupt
    always_comb begin
        mask_cg = 8'hFF;
        mask_cg[`FEM_BIT_CRC]      = 1'b0;
        mask_cg[`FEM_BIT_GAIN_LIM] = MASK_GAIN_I[`FEM_BIT_GAIN_LIM];
        next_irq = |(ltch_lf & ~MASK_LIM_I)
                 | |(ltch_cg & ~mask_cg)
                 | |(ltch_cb & ~mask_cb)
                 | |(ltch_ts & ~mask_ts)
                 | |(ltch_pl & ~mask_pl);
        next_shdn = |(live_lf & `FEM_SHDN_LF)
                  | |(live_cg & `FEM_SHDN_CG)
                  | |(live_cb & `FEM_SHDN_CB)
                  | |(live_ts & `FEM_SHDN_TS)
                  | |(live_pl & `FEM_SHDN_PL);
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            irq  <= 1'b0;
            shdn <= 1'b0;
        end else begin
            irq  <= next_irq;
            shdn <= next_shdn;
        end
    end

    assign IRQ_O      = irq;
    assign SHUTDOWN_O = shdn;

    ////////////////////////////////////////////////////////////////////////
    // read data, registered during the wait cycle

    fem_byte_t rd_byte;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    // unmapped indices and upper lanes read as zero
    always_comb begin
        case (idx)
            `FEM_OFS_MASK_CB:   rd_byte = mask_cb;
            `FEM_OFS_MASK_TS:   rd_byte = mask_ts;
            `FEM_OFS_MASK_PL:   rd_byte = mask_pl;
            `FEM_OFS_LIVE_LF:   rd_byte = live_lf;
            `FEM_OFS_LIVE_CG:   rd_byte = live_cg;
            `FEM_OFS_LIVE_CB:   rd_byte = live_cb;
            `FEM_OFS_LIVE_TS:   rd_byte = live_ts;
            `FEM_OFS_LIVE_PL:   rd_byte = live_pl;
            `FEM_OFS_LTCH_LF:   rd_byte = ltch_lf;
            `FEM_OFS_LTCH_CG:   rd_byte = ltch_cg;
            `FEM_OFS_LTCH_CB:   rd_byte = ltch_cb;
            `FEM_OFS_LTCH_TS:   rd_byte = ltch_ts;
            `FEM_OFS_LTCH_PL:   rd_byte = ltch_pl;
            `FEM_OFS_LTCH_TYPE: rd_byte = {5'h00, clk_type};
            default:            rd_byte = 8'h00;
        endcase
        next_rdata = rdata;
        if (READ_I && !ack) begin
            next_rdata = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign READDATA_O = rdata;

endmodule

// File: tb/fem_top_properties.sv
// timing checks on the ports of the fault event block
// assumes one clock domain; conditions reach the outputs in two cycles
`timescale 1ns/1ns
module fem_props
    import fem_pkg::*;
(
    // clock and reset
    input wire logic        CLOCK_I,
    input wire logic        ARST_N_I,
    // bus
    input wire logic        READ_I,
    input wire logic        WRITE_I,
    input wire logic [31:0] READDATA_O,
    input wire logic        WAITREQUEST_O,
    // conditions and results
    input wire fem_cond_s   COND_I,
    input wire logic [7:0]  MASK_LIM_I,
    input wire logic        IRQ_O,
    input wire logic        SHUTDOWN_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!ARST_N_I);

    ////////////////////////////////////////////////////////////////////////
    // every condition that must force shutdown, gathered once
    logic shdn_cond;
    assign shdn_cond = COND_I.audio_clock_error_live | COND_I.overcurrent_live
        | COND_I.overtemperature_live | COND_I.fuse_memory_crc_live
        | COND_I.derived_clock_error_live | COND_I.battery_undervoltage_live
        | COND_I.regulator_undervoltage_live
        | COND_I.regulator_overvoltage_live | COND_I.regulator_overload_live
        | COND_I.power_stage_undervoltage_live
        | COND_I.thermal_threshold_two_live;

    ////////////////////////////////////////////////////////////////////////
    // bus answers after exactly one wait cycle, upper lanes read zero
    bus_wait_a: assert property (
        $rose(READ_I | WRITE_I) |-> WAITREQUEST_O ##1 !WAITREQUEST_O)
        else $error("bus answer not after one wait cycle");
    rdata_high_a: assert property (
        READ_I && !WAITREQUEST_O |-> READDATA_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    // shutdown classes, two cycles after the condition
    shdn_fault_a: assert property (
        COND_I.audio_clock_error_live | COND_I.overcurrent_live
        | COND_I.overtemperature_live |-> ##2 SHUTDOWN_O)
        else $error("fault did not shut down");
    shdn_crc_a: assert property (
        COND_I.fuse_memory_crc_live |-> ##2 SHUTDOWN_O)
        else $error("crc error did not shut down");
    shdn_clock_a: assert property (
        COND_I.derived_clock_error_live | COND_I.battery_undervoltage_live
        |-> ##2 SHUTDOWN_O)
        else $error("clock or battery fault did not shut down");
    shdn_supply_a: assert property (
        COND_I.regulator_undervoltage_live | COND_I.regulator_overload_live
        | COND_I.regulator_overvoltage_live
        | COND_I.power_stage_undervoltage_live |-> ##2 SHUTDOWN_O)
        else $error("supply fault did not shut down");
    shdn_thermal_a: assert property (
        COND_I.thermal_threshold_two_live |-> ##2 SHUTDOWN_O)
        else $error("thermal threshold two did not shut down");
    // warnings alone never shut down, and shutdown ends with its cause
    shdn_quiet_a: assert property (
        !shdn_cond ##1 !shdn_cond |=> !SHUTDOWN_O)
        else $error("shutdown without a shutdown condition");
    // unmasked events raise the interrupt; crc has no mask
    irq_fault_a: assert property (
        COND_I.overcurrent_live && !MASK_LIM_I[1] |-> ##2 IRQ_O)
        else $error("unmasked overcurrent gave no interrupt");
    irq_crc_a: assert property (
        COND_I.fuse_memory_crc_live |-> ##2 IRQ_O)
        else $error("crc error gave no interrupt");
endmodule

bind fem_top fem_props u_props (.CLOCK_I, .ARST_N_I, .READ_I, .WRITE_I,
    .READDATA_O, .WAITREQUEST_O, .COND_I, .MASK_LIM_I, .IRQ_O, .SHUTDOWN_O);

// File: tb/fem_top_tb.sv
// self-checking bench for fem_top: masks, live and latched status
// assumes the checker binds itself; bus waits are bounded
`timescale 1ns/1ns
`include "fem_map.svh"
module fem_top_tb
    import fem_pkg::*;
;
    logic        CLOCK_I;
    logic        ARST_N_I;
    logic [7:0]  ADDRESS_I;
    logic        READ_I;
    logic        WRITE_I;
    logic [31:0] WRITEDATA_I;
    logic [31:0] READDATA_O;
    logic        WAITREQUEST_O;
    fem_cond_s   COND_I;
    logic [3:0]  BYTEENABLE_I;
    logic [2:0]  CLK_ERR_TYPE_I;
    logic [7:0]  MASK_LIM_I;
    logic [7:0]  MASK_GAIN_I;
    logic        IRQ_O;
    logic        SHUTDOWN_O;
    int          errors;
    int          n_compared;

    fem_top dut (.CLOCK_I, .ARST_N_I, .ADDRESS_I, .READ_I, .WRITE_I,
        .WRITEDATA_I, .BYTEENABLE_I, .READDATA_O, .WAITREQUEST_O,
        .COND_I, .CLK_ERR_TYPE_I, .MASK_LIM_I, .MASK_GAIN_I,
        .IRQ_O, .SHUTDOWN_O);

    // 250 MHz clock
    initial begin
        CLOCK_I = 1'b0;
        forever #2 CLOCK_I = ~CLOCK_I;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("counts: compared %0d bad %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus cycle; sampled mid-cycle so the edge values are settled
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int   n;
        logic w;
        ADDRESS_I   <= a;
        WRITEDATA_I <= d;
        READ_I      <= !wr;
        WRITE_I     <= wr;
        n = 0;
        w = 1'b1;
        while (w !== 1'b0 && n < 20) begin
            @(negedge CLOCK_I);
            w = WAITREQUEST_O;
            q = READDATA_O;
            @(posedge CLOCK_I);
            n++;
        end
        if (w !== 1'b0) begin
            errors++;
            stop_test();
        end
        READ_I  <= 1'b0;
        WRITE_I <= 1'b0;
        @(posedge CLOCK_I); // idle gap keeps requests apart
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask

    // wait n edges, then look at irq (sel=1) or shutdown mid-cycle
    task automatic flag(input int n, input logic sel, input logic exp);
        repeat (n) @(posedge CLOCK_I);
        @(negedge CLOCK_I);
        chk({31'h0, sel ? IRQ_O : SHUTDOWN_O}, {31'h0, exp});
        @(posedge CLOCK_I);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] live[5] = '{8'h42, 8'h43, 8'h44, 8'h47, 8'h48};
        rd(`FEM_OFS_MASK_CB, 32'hDF);
        rd(`FEM_OFS_MASK_TS, 32'hF6);
        rd(`FEM_OFS_MASK_PL, 32'h00);
        foreach (live[i]) rd(live[i], 32'h00);
        rd(8'h00, 32'h00);
        $display("test reset values done");
    endtask

    // masks read back; read-only and unmapped writes are dropped
    task automatic t_access;
        logic [7:0] ofs[3] = '{8'h3D, 8'h40, 8'h41};
        logic [7:0] rst[3] = '{8'hDF, 8'hF6, 8'h00};
        logic [7:0] live[5] = '{8'h42, 8'h43, 8'h44, 8'h47, 8'h48};
        foreach (ofs[i]) begin
            wr(ofs[i], 8'h5A ^ rst[i]);
            rd(ofs[i], {24'h0, 8'h5A ^ rst[i]});
            wr(ofs[i], rst[i]);
        end
        // a write with lane 0 disabled must leave the mask alone
        BYTEENABLE_I <= 4'hE;
        wr(`FEM_OFS_MASK_PL, 8'hFF);
        BYTEENABLE_I <= 4'h1;
        rd(`FEM_OFS_MASK_PL, 32'h00);
        foreach (live[i]) begin
            wr(live[i], 8'hFF);
            rd(live[i], 32'h00);
        end
        wr(8'h3E, 8'hFF);
        rd(8'h3E, 32'h00);
        $display("test register access done");
    endtask

    // each condition alone: its live bit, shutdown class, self-clear
    task automatic t_live;
        logic [28:0] shdn = 29'h0F30F80;
        logic [7:0]  a;
        int          b;
        for (int i = 0; i < 29; i++) begin
            if (i >= 21) begin
                a = 8'h42;
                b = i - 21;
            end else if (i >= 16) begin
                a = (i >= 18) ? 8'h43 : 8'h44;
                b = (i == 20) ? 6 : (i == 19) ? 2 : (i == 18) ? 0
                  : (i == 17) ? 7 : 5;
            end else begin
                a = (i >= 8) ? 8'h47 : 8'h48;
                b = i % 8;
            end
            COND_I <= fem_cond_s'(29'h1 << i);
            flag(3, 1'b0, shdn[i]);
            rd(a, 32'h1 << b);
            COND_I <= '0;
            flag(3, 1'b0, 1'b0);
            rd(a, 32'h00);
        end
        $display("test live status done");
    endtask

    // latched copies hold until read, then clear the interrupt
    task automatic t_latch;
        logic [7:0]  a[6] = '{8'h49, 8'h4A, 8'h4B, 8'h4F, 8'h50, 8'h51};
        logic [31:0] e[6] = '{32'hFF, 32'h41, 32'hA0, 32'hFF, 32'hFF,
                              32'h05};
        flag(0, 1'b1, 1'b1);
        foreach (a[i]) rd(a[i], e[i]);
        foreach (a[i]) rd(a[i], 32'h00);
        flag(2, 1'b1, 1'b0);
        $display("test latched status done");
    endtask

    // a masked event is held back until its mask bit is cleared
    task automatic t_mask;
        wr(`FEM_OFS_MASK_CB, 8'hFF);
        COND_I.battery_undervoltage_live <= 1'b1;
        @(posedge CLOCK_I);
        COND_I <= '0;
        flag(3, 1'b1, 1'b0);
        wr(`FEM_OFS_MASK_CB, 8'hDF);
        flag(2, 1'b1, 1'b1);
        rd(`FEM_OFS_LTCH_CB, 32'h20);
        flag(2, 1'b1, 1'b0);
        $display("test masking done");
    endtask

    // lower mask inputs gate the interrupt; type only caught on clock error
    task automatic t_lowmask;
        MASK_LIM_I     <= 8'h02;
        MASK_GAIN_I    <= 8'h01;
        CLK_ERR_TYPE_I <= 3'h2;
        COND_I         <= fem_cond_s'(29'h0440000); // overcurrent, gain
        @(posedge CLOCK_I);
        COND_I <= '0;
        flag(3, 1'b1, 1'b0);
        rd(`FEM_OFS_LTCH_LF, 32'h02);
        rd(`FEM_OFS_LTCH_CG, 32'h01);
        rd(`FEM_OFS_LTCH_TYPE, 32'h00);
        MASK_LIM_I     <= 8'h00;
        MASK_GAIN_I    <= 8'h00;
        CLK_ERR_TYPE_I <= 3'h5;
        $display("test lower masks done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset for 20 cycles, then run every scenario
    initial begin
        errors = 0;
        n_compared = 0;
        ARST_N_I = 1'b0;
        ADDRESS_I = 8'h00;
        READ_I = 1'b0;
        WRITE_I = 1'b0;
        WRITEDATA_I = 32'h0;
        COND_I = '0;
        BYTEENABLE_I = 4'h1;
        CLK_ERR_TYPE_I = 3'h5;
        MASK_LIM_I = 8'h00;
        MASK_GAIN_I = 8'h00;
        repeat (20) @(posedge CLOCK_I);
        ARST_N_I <= 1'b1;
        @(posedge CLOCK_I);
        t_reset();
        t_access();
        t_live();
        t_latch();
        t_mask();
        t_lowmask();
        stop_test();
    end
endmodule
